// ### rtl/spiee_pkg.sv
// Shared constants and types for the serial port and EEPROM passthrough block
package spiee_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int MCLK_PERIOD_PS = 4000;
    localparam int EE_HALF_NS = 20;
    // Least half period, rounded up to whole core cycles
    localparam int EE_HALF_CYC = (EE_HALF_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int STRAP_WAIT = 3;
    localparam int CFG_BYTES_DEF = 16;
    // ****************************************
    // Configuration read sequence
    // ****************************************
    localparam logic [7:0] EE_READ_CMD = 8'h03;
    localparam logic [15:0] EE_START_ADDR = 16'h0000;
    localparam int EE_HDR_BITS = 24;
    localparam logic [7:0] TX_IDLE_BYTE = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } spiee_eepins_s;
    localparam spiee_eepins_s EE_IDLE = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    typedef enum logic [1:0] {CF_BOOT, CF_XFER, CF_DONE} spiee_cfg_e;
endpackage : spiee_pkg

// ### rtl/spiee_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/10ps
module spiee_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : spiee_sync

// ### rtl/spiee_top.sv
// Host serial slave port, EEPROM autoconfiguration master and passthrough
`timescale 1ns/10ps
module spiee_top
    import spiee_pkg::*;
#(
    parameter int CFG_BYTES = CFG_BYTES_DEF
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // Host serial port
    input wire logic HOST_SCLK_I,
    input wire logic HOST_SELECT_N_I,
    input wire logic HOST_DATA_IN_I,
    output logic HOST_DATA_OUT_O,
    output logic HOST_DATA_OUT_OE_N_O,
    // Host byte stream to and from the register layer
    output logic [7:0] HOST_RX_BYTE_O,
    output logic HOST_RX_VALID_O,
    input wire logic [7:0] HOST_TX_BYTE_I,
    input wire logic HOST_TX_LOAD_I,
    // EEPROM master port
    output logic EEPROM_SELECT_N_O,
    output logic EEPROM_SERIAL_CLOCK_O,
    output logic EEPROM_DATA_TO_MEM_O,
    input wire logic EEPROM_DATA_FROM_MEM_I,
    // Control and configuration stream
    input wire logic EEPROM_PASSTHROUGH_SELECT_I,
    input wire logic AUTOCONFIG_STRAP_I,
    output logic [7:0] CFG_BYTE_O,
    output logic CFG_VALID_O,
    output logic CFG_BUSY_O,
    output logic CFG_DONE_O
);
    localparam logic [15:0] TOTAL_BITS = 16'(EE_HDR_BITS + 8 * CFG_BYTES);
    localparam logic [7:0] HALF_LAST = 8'(EE_HALF_CYC - 1);

    // ****************************************
    // Host clock domain: byte shifter
    // ****************************************
    logic [2:0] s_cnt_q;
    logic [7:0] s_rx_sr_q;
    logic [7:0] s_tx_sr_q;
    logic [7:0] s_rx_byte_q;
    logic s_rx_tgl_q;
    logic s_tx_seen_q;
    logic s_tx_tgl;
    logic [7:0] tx_hold_q;
    logic tx_tgl_q;
    wire s_rst = RST_I | HOST_SELECT_N_I;
    wire s_last = s_cnt_q == BIT_LAST;
    wire s_tx_new = s_tx_tgl != s_tx_seen_q;
    wire [7:0] s_rx_full = {s_rx_sr_q[6:0], HOST_DATA_IN_I};

    spiee_sync #(.W(1)) u_tx_sync (
        .clk_i(HOST_SCLK_I),
        .rst_i(RST_I),
        .d_i(tx_tgl_q),
        .q_o(s_tx_tgl)
    );

    // Frame state clears whenever select is high
    always_ff @(posedge HOST_SCLK_I or posedge s_rst)
    begin
        if (s_rst)
        begin
            s_cnt_q <= '0;
            s_rx_sr_q <= '0;
            s_tx_sr_q <= TX_IDLE_BYTE;
        end
        else
        begin
            s_cnt_q <= s_cnt_q + 3'h1;
            s_rx_sr_q <= s_rx_full;
            // Next bit is shown a full period early to cover the crossing
            s_tx_sr_q <= s_last ? (s_tx_new ? tx_hold_q : TX_IDLE_BYTE)
                                : {s_tx_sr_q[6:0], 1'b0};
        end
    end

    // Handshake state survives across frames
    always_ff @(posedge HOST_SCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            s_rx_byte_q <= '0;
            s_rx_tgl_q <= 1'b0;
            s_tx_seen_q <= 1'b0;
        end
        else if (s_last && !HOST_SELECT_N_I)
        begin
            s_rx_byte_q <= s_rx_full;
            s_rx_tgl_q <= ~s_rx_tgl_q;
            s_tx_seen_q <= s_tx_tgl;
        end
    end

    // ****************************************
    // Core domain: pin synchronisers
    // ****************************************
    logic [7:0] sy;
    spiee_sync #(.W(8)) u_pin_sync (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .d_i({s_rx_tgl_q, s_tx_sr_q[7], HOST_SELECT_N_I, HOST_SCLK_I, HOST_DATA_IN_I,
              EEPROM_DATA_FROM_MEM_I, AUTOCONFIG_STRAP_I, EEPROM_PASSTHROUGH_SELECT_I}),
        .q_o(sy)
    );
    wire rx_tgl_s = sy[7];
    wire slv_bit_s = sy[6];
    wire host_cs_n_s = sy[5];
    wire host_sclk_s = sy[4];
    wire host_sdi_s = sy[3];
    wire miso_s = sy[2];
    wire strap_s = sy[1];
    wire pass_sel_s = sy[0];

    // ****************************************
    // Core domain: host byte stream
    // ****************************************
    logic rx_seen_q;
    wire rx_new = rx_tgl_s != rx_seen_q;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rx_seen_q <= 1'b0;
            HOST_RX_BYTE_O <= '0;
            HOST_RX_VALID_O <= 1'b0;
            tx_hold_q <= TX_IDLE_BYTE;
            tx_tgl_q <= 1'b0;
        end
        else
        begin
            rx_seen_q <= rx_tgl_s;
            HOST_RX_VALID_O <= rx_new;
            if (rx_new)
                HOST_RX_BYTE_O <= s_rx_byte_q;
            if (HOST_TX_LOAD_I)
            begin
                tx_hold_q <= HOST_TX_BYTE_I;
                tx_tgl_q <= ~tx_tgl_q;
            end
        end
    end

    // ****************************************
    // Core domain: autoconfiguration master
    // ****************************************
    spiee_cfg_e st_q, st_d;
    logic [1:0] boot_q;
    logic [7:0] div_q;
    logic [15:0] bit_q;
    logic [23:0] hdr_q;
    logic [7:0] crx_q;
    logic csclk_q;
    wire cfg_act = st_q == CF_XFER;
    wire half_end = div_q == HALF_LAST;
    wire rise = cfg_act && half_end && !csclk_q;
    wire fall = cfg_act && half_end && csclk_q;
    wire boot_end = st_q == CF_BOOT && boot_q == 2'(STRAP_WAIT - 1);
    wire in_data = bit_q >= 16'(EE_HDR_BITS);
    wire byte_end = rise && in_data && bit_q[2:0] == BIT_LAST;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            CF_BOOT: if (boot_end) st_d = strap_s ? CF_XFER : CF_DONE;
            CF_XFER: if (fall && bit_q == TOTAL_BITS) st_d = CF_DONE;
            CF_DONE: st_d = CF_DONE;
            default: st_d = CF_DONE;
        endcase
    end

    // Strap is read only after release, through the synchroniser
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_q <= CF_BOOT;
            boot_q <= '0;
            div_q <= '0;
            bit_q <= '0;
            hdr_q <= '0;
            crx_q <= '0;
            csclk_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            boot_q <= boot_q + 2'h1;
            div_q <= (half_end || !cfg_act) ? 8'h00 : div_q + 8'h01;
            if (boot_end)
                hdr_q <= {EE_READ_CMD, EE_START_ADDR};
            else if (fall)
                hdr_q <= {hdr_q[22:0], 1'b0};
            if (rise)
            begin
                csclk_q <= 1'b1;
                bit_q <= bit_q + 16'h0001;
                crx_q <= {crx_q[6:0], miso_s};
            end
            else if (fall)
                csclk_q <= 1'b0;
        end
    end

    // ****************************************
    // Core domain: output selection
    // ****************************************
    wire pass_act = pass_sel_s && !host_cs_n_s && st_q == CF_DONE;
    spiee_eepins_s ee_d, ee_q;
    assign ee_d = cfg_act ? spiee_eepins_s'{cs_n: 1'b0, sclk: csclk_q, mosi: hdr_q[23]}
                : pass_act ? spiee_eepins_s'{cs_n: host_cs_n_s, sclk: host_sclk_s,
                                             mosi: host_sdi_s}
                : EE_IDLE;
    wire sdo_d = pass_act ? miso_s : slv_bit_s;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ee_q <= EE_IDLE;
            HOST_DATA_OUT_O <= 1'b0;
            HOST_DATA_OUT_OE_N_O <= 1'b1;
            CFG_BYTE_O <= '0;
            CFG_VALID_O <= 1'b0;
            CFG_BUSY_O <= 1'b0;
            CFG_DONE_O <= 1'b0;
        end
        else
        begin
            ee_q <= ee_d;
            HOST_DATA_OUT_O <= sdo_d;
            HOST_DATA_OUT_OE_N_O <= host_cs_n_s;
            CFG_VALID_O <= byte_end;
            if (byte_end)
                CFG_BYTE_O <= {crx_q[6:0], miso_s};
            CFG_BUSY_O <= st_d == CF_XFER;
            CFG_DONE_O <= st_d == CF_DONE;
        end
    end
    assign EEPROM_SELECT_N_O = ee_q.cs_n;
    assign EEPROM_SERIAL_CLOCK_O = ee_q.sclk;
    assign EEPROM_DATA_TO_MEM_O = ee_q.mosi;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    AST_IDLE_PINS: assert property (!cfg_act && !pass_act |=>
        EEPROM_SELECT_N_O && !EEPROM_SERIAL_CLOCK_O && !EEPROM_DATA_TO_MEM_O)
        else $error("EEPROM pins not idle");
    AST_PASS_SEL: assert property (pass_act |=> !EEPROM_SELECT_N_O)
        else $error("Passthrough select not low");
    AST_PASS_CLK: assert property (pass_act |=> EEPROM_SERIAL_CLOCK_O == $past(host_sclk_s))
        else $error("Passthrough clock mismatch");
    AST_PASS_MOSI: assert property (pass_act |=> EEPROM_DATA_TO_MEM_O == $past(host_sdi_s))
        else $error("Passthrough data mismatch");
    AST_PASS_MISO: assert property (pass_act |=> HOST_DATA_OUT_O == $past(miso_s))
        else $error("Passthrough read data mismatch");
    AST_HIZ: assert property (host_cs_n_s |=> HOST_DATA_OUT_OE_N_O)
        else $error("Host output driven while deselected");
    AST_CFG_SEL: assert property (cfg_act |=> !EEPROM_SELECT_N_O)
        else $error("EEPROM select high during fetch");
    AST_CFG_HALF: assert property (cfg_act && $changed(csclk_q) |=> $stable(csclk_q) [*4])
        else $error("EEPROM clock half period too short");
    // Last command bit lands seven clock periods on; assumes a five-cycle half period
    AST_CFG_CMD: assert property (boot_end && strap_s |=> ##1
        (EEPROM_DATA_TO_MEM_O == EE_READ_CMD[7] && !EEPROM_SELECT_N_O)
        ##70 EEPROM_DATA_TO_MEM_O == EE_READ_CMD[0])
        else $error("Read command not sent");
    AST_STRAP: assert property (boot_end && !strap_s |=> st_q == CF_DONE [*2])
        else $error("Fetch started without strap");
    AST_BYTE: assert property (byte_end |=> CFG_VALID_O && CFG_BYTE_O[0] == $past(miso_s))
        else $error("Configuration byte not captured");

    COV_FETCH: cover property (cfg_act ##1 st_q == CF_DONE);
    COV_PASS: cover property (pass_act ##1 !pass_act);
    COV_RX: cover property (HOST_RX_VALID_O);
endmodule : spiee_top

// ### sim/spiee_eeprom_model.sv
// Behavioural serial EEPROM answering the configuration read
`timescale 1ns/10ps
module spiee_eeprom_model (
    // Memory pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Header seen by the memory
    output logic [23:0] hdr_o
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    initial
    begin
        miso_o = 1'b0;
        hdr_o = 24'h00_0000;
    end
    always @(negedge cs_n_i) cnt = 0;
    // Released line: show the inverse, never a stale bit
    always @(posedge cs_n_i) miso_o = ~miso_o;
    // Header bits taken on rising edge
    always @(posedge sclk_i)
    begin
        if (!cs_n_i)
        begin
            if (cnt < 24)
                hdr_o = {hdr_o[22:0], mosi_i};
            cnt++;
        end
    end
    // Data byte n is 0xA5 xor n, launched on falling edge
    always @(negedge sclk_i)
    begin
        if (!cs_n_i && cnt >= 24)
        begin
            if ((cnt - 24) % 8 == 0)
                sh = 8'hA5 ^ 8'((cnt - 24) / 8);
            miso_o = sh[7 - ((cnt - 24) % 8)];
        end
    end
endmodule : spiee_eeprom_model

// ### sim/test_spiee_top.sv
// Self-checking bench for the serial port and EEPROM passthrough block
`timescale 1ns/10ps
module test_spiee_top;
    import spiee_pkg::*;
    localparam int NB = 2;
    logic mclk = 1'b0;
    logic rst = 1'b0;
    logic hsclk = 1'b0;
    logic hsel_n = 1'b0;
    logic hdin = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic tx_load = 1'b0;
    logic pass = 1'b0;
    logic strap = 1'b0;
    logic hdout, oe_n, rx_valid, ee_cs_n, ee_clk, ee_mosi, ee_miso, cfg_valid, busy, done;
    logic [7:0] rx_byte, cfg_byte;
    logic [23:0] hdr;
    int err_count = 0;
    int checked = 0;
    always #2 mclk = ~mclk;
    spiee_top #(.CFG_BYTES(NB)) i_spiee_top (.MCLK_I(mclk), .RST_I(rst),
        .HOST_SCLK_I(hsclk), .HOST_SELECT_N_I(hsel_n), .HOST_DATA_IN_I(hdin),
        .HOST_DATA_OUT_O(hdout), .HOST_DATA_OUT_OE_N_O(oe_n), .HOST_RX_BYTE_O(rx_byte),
        .HOST_RX_VALID_O(rx_valid), .HOST_TX_BYTE_I(tx_byte), .HOST_TX_LOAD_I(tx_load),
        .EEPROM_SELECT_N_O(ee_cs_n), .EEPROM_SERIAL_CLOCK_O(ee_clk),
        .EEPROM_DATA_TO_MEM_O(ee_mosi), .EEPROM_DATA_FROM_MEM_I(ee_miso),
        .EEPROM_PASSTHROUGH_SELECT_I(pass), .AUTOCONFIG_STRAP_I(strap),
        .CFG_BYTE_O(cfg_byte), .CFG_VALID_O(cfg_valid), .CFG_BUSY_O(busy), .CFG_DONE_O(done));
    spiee_eeprom_model i_spiee_eeprom_model (.cs_n_i(ee_cs_n), .sclk_i(ee_clk),
        .mosi_i(ee_mosi), .miso_o(ee_miso), .hdr_o(hdr));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic check_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit
    task automatic check_vec(input string nm, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check_vec
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic guard(input int k, input int lim);
        if (k >= lim)
        begin
            err_count++;
            $display("mismatch wait expected event seen timeout");
            tally_and_finish();
        end
    endtask : guard
    task automatic do_reset(input logic s);
        rst = 1'b1;
        strap = s;
        hsel_n = 1'b1;
        tick(4);
        check_bit("ee_select_n", 1'b1, ee_cs_n);
        check_bit("ee_clock", 1'b0, ee_clk);
        check_bit("host_oe_n", 1'b1, oe_n);
        check_bit("cfg_done", 1'b0, done);
        rst = 1'b0;
    endtask : do_reset
    // Link clock runs only inside frames, 15 ns period
    // Host samples the returned bit just before each rising edge
    task automatic link_bits(input logic [7:0] b, input int nb, output logic [7:0] got);
        got = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            hdin = b[i];
            #3.75 got = {got[6:0], hdout};
            hsclk = 1'b1;
            #7.5 hsclk = 1'b0;
            #3.75;
        end
    endtask : link_bits
    task automatic host_byte(input logic [7:0] b, input logic [7:0] e);
        int k;
        logic [7:0] got;
        k = 0;
        link_bits(b, 8, got);
        while (rx_valid !== 1'b1 && k < 12)
        begin
            tick(1);
            k++;
        end
        guard(k, 12);
        check_vec("rx_byte", {16'h0000, b}, {16'h0000, rx_byte});
        check_vec("host_data_out", {16'h0000, e}, {16'h0000, got});
    endtask : host_byte
    task automatic scn_strap_low;
        do_reset(1'b0);
        tick(6);
        check_bit("cfg_done", 1'b1, done);
        check_bit("cfg_busy", 1'b0, busy);
        check_bit("ee_select_n", 1'b1, ee_cs_n);
    endtask : scn_strap_low
    task automatic scn_host_bytes;
        int seen;
        logic [7:0] part;
        seen = 0;
        hsel_n = 1'b0;
        tick(6);
        check_bit("host_oe_n", 1'b0, oe_n);
        tx_byte = 8'h3C;
        tx_load = 1'b1;
        tick(1);
        tx_load = 1'b0;
        host_byte(8'h5A, 8'h00);
        host_byte(8'hC3, 8'h3C);
        // Partial byte then deselect: must leave no trace
        link_bits(8'hFF, 4, part);
        check_vec("host_data_out", 24'h00_0000, {16'h0000, part});
        hsel_n = 1'b1;
        repeat (20)
        begin
            tick(1);
            if (rx_valid === 1'b1)
                seen++;
        end
        check_vec("rx_pulses", 24'h00_0000, 24'(seen));
        check_bit("host_oe_n", 1'b1, oe_n);
        check_bit("ee_select_n", 1'b1, ee_cs_n);
        hsel_n = 1'b0;
        tick(6);
        host_byte(8'h81, 8'h00);
        hsel_n = 1'b1;
        tick(6);
    endtask : scn_host_bytes
    task automatic scn_passthrough;
        pass = 1'b1;
        tick(4);
        hsel_n = 1'b0;
        tick(8);
        check_bit("ee_select_n", 1'b0, ee_cs_n);
        for (int v = 1; v >= 0; v--)
        begin
            hsclk = 1'(v);
            hdin = 1'(v);
            tick(8);
            check_bit("ee_clock", 1'(v), ee_clk);
            check_bit("ee_data_to_mem", 1'(v), ee_mosi);
            check_bit("host_data_out", ee_miso, hdout);
        end
        hsel_n = 1'b1;
        tick(8);
        check_bit("ee_select_n", 1'b1, ee_cs_n);
        check_bit("ee_clock", 1'b0, ee_clk);
        pass = 1'b0;
        tick(4);
    endtask : scn_passthrough
    task automatic scn_autoconfig;
        int k;
        int n;
        int rises;
        logic prev;
        do_reset(1'b1);
        k = 0;
        while (busy !== 1'b1 && k < 10)
        begin
            tick(1);
            k++;
        end
        guard(k, 10);
        check_bit("cfg_busy", 1'b1, busy);
        tick(2);
        check_bit("ee_select_n", 1'b0, ee_cs_n);
        n = 0;
        rises = 0;
        prev = ee_clk;
        k = 0;
        while (!(done === 1'b1 && ee_cs_n === 1'b1) && k < 3000)
        begin
            tick(1);
            k++;
            if (ee_clk === 1'b1 && prev === 1'b0)
                rises++;
            prev = ee_clk;
            if (cfg_valid === 1'b1)
            begin
                check_vec("cfg_byte", {16'h0000, 8'hA5 ^ 8'(n)}, {16'h0000, cfg_byte});
                n++;
            end
        end
        guard(k, 3000);
        check_vec("cfg_count", 24'(NB), 24'(n));
        check_vec("ee_clock_rises", 24'(EE_HDR_BITS + 8 * NB), 24'(rises));
        check_vec("ee_header", {EE_READ_CMD, EE_START_ADDR}, hdr);
        check_bit("ee_clock", 1'b0, ee_clk);
    endtask : scn_autoconfig
    initial
    begin
        // Reset is raised after all processes wait, so its edge is seen
        tick(1);
        scn_strap_low();
        scn_host_bytes();
        scn_passthrough();
        scn_autoconfig();
        tally_and_finish();
    end
    initial
    begin
        #300000;
        err_count++;
        $display("mismatch run expected end seen timeout");
        tally_and_finish();
    end
endmodule : test_spiee_top
